// File: bench/slp_board.sv
`timescale 1ns/100ps
`default_nettype none
module slp_board (
    input wire slp_pkg::slp_port_t primary_port_indicator_out,
    input wire slp_pkg::slp_port_t primary_port_indicator_oe,
    input wire slp_pkg::slp_port_t swap_pull,
    output var slp_pkg::slp_port_t primary_port_indicator_in,
    input wire slp_pkg::slp_sec_t  secondary_port_indicator_out,
    input wire slp_pkg::slp_sec_t  secondary_port_indicator_oe,
    input wire logic               gang_pull,
    output var slp_pkg::slp_sec_t  secondary_port_indicator_in
);
    import slp_pkg::*;
    // strap resistor sets the level whenever the hub lets go of the pin
    assign primary_port_indicator_in = (primary_port_indicator_oe & primary_port_indicator_out) |
        (~primary_port_indicator_oe & swap_pull);
    // ports 4-7 have no strap: the lamp to supply pulls them high
    assign secondary_port_indicator_in = (secondary_port_indicator_oe & secondary_port_indicator_out) |
        (~secondary_port_indicator_oe & {4'hF, gang_pull});
endmodule
`default_nettype wire

// File: bench/slp_strap_led_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module slp_strap_led_asserts (
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic               s_axi_arvalid,
    input wire logic               s_axi_arready,
    input wire logic               s_axi_rvalid,
    input wire logic               upstream_power_detect,
    input wire slp_pkg::slp_port_t primary_port_indicator_out,
    input wire slp_pkg::slp_port_t primary_port_indicator_oe,
    input wire slp_pkg::slp_sec_t  secondary_port_indicator_oe,
    input wire slp_pkg::slp_port_t port_power_enable,
    input wire slp_pkg::slp_port_t port_disabled,
    input wire slp_pkg::slp_port_t data_line_swap,
    input wire logic               gang_mode,
    input wire logic               upstream_pullup_enable
);
    import slp_pkg::*;
    // edges since reset release, saturating; gates checks that would see reset history
    logic [2:0] cnt_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= 3'h0;
        end else if (cnt_r != 3'h7) begin
            cnt_r <= cnt_r + 3'h1;
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_pullup_follows_power: assert property (cnt_r >= 3'h4 |->
        upstream_pullup_enable == $past(upstream_power_detect, 3)) else $error("pull-up does not follow power detect");
    chk_quiet_before_sample: assert property (cnt_r < 3'h5 |->
        port_power_enable == '0 && primary_port_indicator_oe == '0) else $error("pins active before sampling");
    chk_straps_held: assert property (cnt_r >= 3'h6 |-> $stable(port_disabled) &&
        $stable(data_line_swap) && $stable(gang_mode)) else $error("strap result changed");
    chk_gang_power_all: assert property (gang_mode && cnt_r == 3'h7 |-> port_power_enable == '0 ||
        port_power_enable == slp_port_t'(~port_disabled)) else $error("ganged power not uniform");
    chk_disabled_unpowered: assert property ((port_power_enable & port_disabled) == '0)
        else $error("disabled port powered");
    chk_led_release_all: assert property ((primary_port_indicator_oe == '0 && secondary_port_indicator_oe == '0) ||
        (&primary_port_indicator_oe && &secondary_port_indicator_oe)) else $error("indicator enables split");
    chk_disabled_lamp_off: assert property (&primary_port_indicator_oe |->
        ((primary_port_indicator_out ^ data_line_swap) & port_disabled) == '0) else $error("disabled lamp lit");
    chk_read_answer_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule
bind slp_strap_led slp_strap_led_asserts i_slp_strap_led_asserts (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .upstream_power_detect, .primary_port_indicator_out, .primary_port_indicator_oe,
    .secondary_port_indicator_oe, .port_power_enable, .port_disabled, .data_line_swap, .gang_mode,
    .upstream_pullup_enable);
`default_nettype wire

// File: bench/tb_slp_strap_led.sv
`timescale 1ns/100ps
`default_nettype none
module tb_slp_strap_led;
    import slp_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, upstream_power_detect = 1'b1, gang_pull = 1'b1;
    logic        strap_enable_port_off = 1'b1, strap_enable_swap = 1'b1, strap_enable_gang = 1'b1;
    slp_port_t   port_off_strap_plus = 7'h01, port_off_strap_minus = 7'h40, swap_pull = 7'h2A;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        gang_mode, upstream_pullup_enable;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    slp_port_t   primary_port_indicator_in, primary_port_indicator_out, primary_port_indicator_oe;
    slp_port_t   port_power_enable, port_disabled, data_line_swap;
    slp_sec_t    secondary_port_indicator_in, secondary_port_indicator_out, secondary_port_indicator_oe;
    int          bad_count = 0, n_checks = 0, cyc = 0;

    always #20 aclk = ~aclk;

    slp_strap_led i_slp_strap_led (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .strap_enable_port_off, .strap_enable_swap, .strap_enable_gang, .upstream_power_detect,
        .port_off_strap_plus, .port_off_strap_minus, .primary_port_indicator_in, .primary_port_indicator_out,
        .primary_port_indicator_oe, .secondary_port_indicator_in, .secondary_port_indicator_out,
        .secondary_port_indicator_oe, .port_power_enable, .port_disabled, .data_line_swap, .gang_mode,
        .upstream_pullup_enable);
    slp_board i_slp_board (.primary_port_indicator_out, .primary_port_indicator_oe, .swap_pull,
        .primary_port_indicator_in, .secondary_port_indicator_out, .secondary_port_indicator_oe, .gang_pull,
        .secondary_port_indicator_in);

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        chk(32'({s_axi_bvalid, s_axi_bresp}), 32'({1'b1, er}));
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        s_axi_rready <= 1'b0;
        chk(32'({s_axi_rvalid, s_axi_rresp}), 32'({1'b1, er}));
        chk(s_axi_rdata, ed);
    endtask

    // leaves 8 edges after release so the latch and the pull-up pipeline have settled
    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (8) @(posedge aclk);
    endtask

    function automatic logic [31:0] st(input logic up, input slp_port_t dis, input slp_port_t sw, input logic g);
        return {14'h0, 1'b1, g, sw, 1'b0, dis, up};
    endfunction

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            complete_run;
        end
    end

    initial begin
        do_reset;
        chk(32'({port_disabled, data_line_swap, gang_mode}), 32'({7'h41, 7'h2A, 1'b1}));
        chk(32'(upstream_pullup_enable), 32'h1);
        rd(8'h08, st(1'b1, 7'h41, 7'h2A, 1'b1), 2'h0);
        rd(8'h00, 32'h0, 2'h0);
        rd(8'h04, 32'h0, 2'h0);
        rd(8'h0C, 32'h0, 2'h2);
        wr(8'h08, 32'hFFFF_FFFF, 2'h2);
        port_off_strap_plus   <= 7'h00;
        port_off_strap_minus  <= 7'h00;
        gang_pull             <= 1'b0;
        upstream_power_detect <= 1'b0;
        repeat (4) @(posedge aclk);
        chk(32'({port_disabled, data_line_swap, gang_mode}), 32'({7'h41, 7'h2A, 1'b1}));
        chk(32'(upstream_pullup_enable), 32'h0);
        $display("test straps latched done");
        wr(8'h00, 32'h0000_0004, 2'h0);
        repeat (2) @(posedge aclk);
        chk(32'(port_power_enable), 32'h3E);
        chk(32'({primary_port_indicator_oe, secondary_port_indicator_oe}), 32'h0);
        wr(8'h04, 32'h0000_281E, 2'h0);
        wr(8'h00, 32'h0000_0005, 2'h0);
        repeat (2) @(posedge aclk);
        chk(32'({primary_port_indicator_oe, secondary_port_indicator_oe}), 32'hFFF);
        chk(32'(primary_port_indicator_out), 32'h24);
        chk(32'(secondary_port_indicator_out), 32'h1A);
        rd(8'h04, 32'h0000_281E, 2'h0);
        $display("test ganged lamps done");
        // straps disabled: pins pulled to non-default levels must be ignored
        strap_enable_port_off <= 1'b0;
        strap_enable_swap     <= 1'b0;
        strap_enable_gang     <= 1'b0;
        port_off_strap_plus   <= 7'h7F;
        gang_pull             <= 1'b1;
        do_reset;
        chk(32'({port_disabled, data_line_swap, gang_mode}), 32'h0);
        wr(8'h00, 32'h0000_0007, 2'h0);
        repeat (2) @(posedge aclk);
        chk(32'(port_power_enable), 32'h03);
        chk(32'(primary_port_indicator_out), 32'h00);
        chk(32'(secondary_port_indicator_out), 32'h1E);
        $display("test default straps done");
        complete_run;
    end
endmodule
`default_nettype wire

// File: hw/slp_led_drv.sv
`timescale 1ns/100ps
`default_nettype none
module slp_led_drv (
    input  wire logic aclk,
    input  wire logic aresetn,
    slp_led_if.drv    led
);
    // pins stay released (read as straps) until drive is granted
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            led.pin_out <= '0;
            led.pin_oe  <= '0;
        end else begin
            led.pin_oe  <= led.drive ? '1 : '0;
            led.pin_out <= led.drive ? (led.lit ^ led.active_low) : '0;
        end
    end
endmodule
`default_nettype wire

// File: hw/slp_strap_led.sv
`timescale 1ns/100ps
`default_nettype none
`include "slp_defines.svh"
module slp_strap_led (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite slave
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // strap enables from package and configuration settings (same clock)
    input  wire logic              strap_enable_port_off,
    input  wire logic              strap_enable_swap,
    input  wire logic              strap_enable_gang,
    // pins
    input  wire logic              upstream_power_detect,
    input  wire slp_pkg::slp_port_t port_off_strap_plus,
    input  wire slp_pkg::slp_port_t port_off_strap_minus,
    input  wire slp_pkg::slp_port_t primary_port_indicator_in,
    output slp_pkg::slp_port_t     primary_port_indicator_out,
    output slp_pkg::slp_port_t     primary_port_indicator_oe,
    input  wire slp_pkg::slp_sec_t secondary_port_indicator_in,
    output slp_pkg::slp_sec_t      secondary_port_indicator_out,
    output slp_pkg::slp_sec_t      secondary_port_indicator_oe,
    output slp_pkg::slp_port_t     port_power_enable,
    output slp_pkg::slp_port_t     port_disabled,
    output slp_pkg::slp_port_t     data_line_swap,
    output logic                   gang_mode,
    output logic                   upstream_pullup_enable
);
    import slp_pkg::*;

    localparam int SW = 23;

    slp_state_e state_r;
    logic [1:0] settle_r;
    logic [31:0] ctrl_r;
    logic [31:0] led_r;
    slp_port_t  port_off_r;
    slp_port_t  swap_r;
    logic       gang_r;
    slp_port_t  pwr_r;
    logic       pullup_r;
    logic [SW-1:0] pins_raw;
    logic [SW-1:0] pins_s;
    logic       upwr_s;
    slp_port_t  plus_s;
    slp_port_t  minus_s;
    slp_port_t  pri_s;
    logic       sec3_s;
    logic       sample;
    logic       led_on;

    // axi state
    logic       awready_r;
    logic       wready_r;
    logic       aw_hold_r;
    logic       w_hold_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic       bvalid_r;
    logic [1:0] bresp_r;
    logic       arready_r;
    logic       rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic       take_aw;
    logic       take_w;
    logic       do_write;
    logic       take_ar;
    logic       aw_hold_nxt;
    logic       w_hold_nxt;
    logic       bvalid_nxt;
    logic       wr_ctrl;
    logic       wr_led;
    logic       wr_ok;
    logic [31:0] status;
    logic [31:0] rd_word;
    logic       rd_ok;

    // every pin passes two flip-flops before any logic looks at it
    assign pins_raw = {upstream_power_detect, port_off_strap_plus, port_off_strap_minus,
                       primary_port_indicator_in, secondary_port_indicator_in[3]};

    slp_sync2 #(
        .W (SW)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (pins_raw),
        .q       (pins_s)
    );

    assign upwr_s  = pins_s[22];
    assign plus_s  = pins_s[21:15];
    assign minus_s = pins_s[14:8];
    assign pri_s   = pins_s[7:1];
    assign sec3_s  = pins_s[0];

    // ---------------- strap sampling ----------------
    // the settle wait lets the synchroniser fill with pin levels after its own reset
    assign sample = (state_r == SLP_SETTLE) && (settle_r == `SLP_SETTLE_CYCLES);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r  <= SLP_SETTLE;
            settle_r <= 2'h0;
        end else begin
            unique case (state_r)
                SLP_SETTLE: begin
                    settle_r <= settle_r + 2'h1;
                    if (sample) begin
                        state_r <= SLP_RUN;
                    end
                end
                SLP_RUN: begin
                    settle_r <= settle_r;
                end
            endcase
        end
    end

    // latched once per reset; nothing but a new reset can change them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_off_r <= `SLP_DEFAULT_PORT_OFF;
            swap_r     <= `SLP_DEFAULT_SWAP;
            gang_r     <= `SLP_DEFAULT_GANG;
        end else if (sample) begin
            port_off_r <= strap_enable_port_off ? (plus_s | minus_s) : `SLP_DEFAULT_PORT_OFF;
            swap_r     <= strap_enable_swap ? pri_s : `SLP_DEFAULT_SWAP;
            gang_r     <= strap_enable_gang ? sec3_s : `SLP_DEFAULT_GANG;
        end
    end

    // ---------------- power and pull-up ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwr_r <= '0;
        end else if (state_r != SLP_RUN) begin
            pwr_r <= '0;
        end else if (gang_r) begin
            // ganged: one switch feeds all live ports, so any request for a live port powers them all
            pwr_r <= (|(ctrl_r[`SLP_CTRL_PWR_LSB +: 7] & ~port_off_r)) ? ~port_off_r : '0;
        end else begin
            pwr_r <= ctrl_r[`SLP_CTRL_PWR_LSB +: 7] & ~port_off_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pullup_r <= 1'b0;
        end else begin
            pullup_r <= upwr_s;
        end
    end

    // ---------------- led drivers ----------------
    assign led_on = ctrl_r[`SLP_CTRL_LED_EN_BIT] && (state_r == SLP_RUN);

    slp_led_if #(.W(7)) pri_if ();
    slp_led_if #(.W(5)) sec_if ();

    assign pri_if.drive      = led_on;
    assign pri_if.lit        = led_r[`SLP_LED_PRI_LSB +: 7] & ~port_off_r;
    assign pri_if.active_low = swap_r;
    assign sec_if.drive      = led_on;
    assign sec_if.lit        = led_r[`SLP_LED_SEC_LSB +: 5] & ~port_off_r[7:3];
    assign sec_if.active_low = {4'hF, gang_r};

    slp_led_drv u_pri (
        .aclk    (aclk),
        .aresetn (aresetn),
        .led     (pri_if)
    );

    slp_led_drv u_sec (
        .aclk    (aclk),
        .aresetn (aresetn),
        .led     (sec_if)
    );

    // ---------------- axi4-lite write ----------------
    assign take_aw  = s_axi_awvalid && awready_r;
    assign take_w   = s_axi_wvalid && wready_r;
    assign do_write = aw_hold_r && w_hold_r && !bvalid_r;
    assign aw_hold_nxt = do_write ? 1'b0 : (take_aw ? 1'b1 : aw_hold_r);
    assign w_hold_nxt  = do_write ? 1'b0 : (take_w ? 1'b1 : w_hold_r);
    assign bvalid_nxt  = do_write ? 1'b1 : ((bvalid_r && s_axi_bready) ? 1'b0 : bvalid_r);

    assign wr_ctrl = do_write && (aw_addr_r == `SLP_CTRL_OFFSET);
    assign wr_led  = do_write && (aw_addr_r == `SLP_LED_OFFSET);
    assign wr_ok   = (aw_addr_r == `SLP_CTRL_OFFSET) || (aw_addr_r == `SLP_LED_OFFSET);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            awready_r <= 1'b0;
            aw_addr_r <= 8'h00;
        end else begin
            aw_hold_r <= aw_hold_nxt;
            awready_r <= !aw_hold_nxt && !bvalid_nxt;
            if (take_aw) begin
                aw_addr_r <= s_axi_awaddr;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_r <= 1'b0;
            wready_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else begin
            w_hold_r <= w_hold_nxt;
            wready_r <= !w_hold_nxt && !bvalid_nxt;
            if (take_w) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `SLP_RESP_OKAY;
        end else begin
            bvalid_r <= bvalid_nxt;
            if (do_write) begin
                bresp_r <= wr_ok ? `SLP_RESP_OKAY : `SLP_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= `SLP_CTRL_RESET;
        end else if (wr_ctrl) begin
            for (int i = 0; i < 4; i++) begin
                if (w_strb_r[i]) begin
                    ctrl_r[8*i +: 8] <= w_data_r[8*i +: 8];
                end
            end
            ctrl_r[31:8] <= 24'h00_0000;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            led_r <= `SLP_LED_RESET;
        end else if (wr_led) begin
            for (int i = 0; i < 4; i++) begin
                if (w_strb_r[i]) begin
                    led_r[8*i +: 8] <= w_data_r[8*i +: 8];
                end
            end
            // only the implemented lamp bits are kept
            led_r[31:16] <= 16'h0000;
            led_r[10:8]  <= 3'h0;
            led_r[0]     <= 1'b0;
        end
    end

    // ---------------- axi4-lite read ----------------
    assign take_ar = s_axi_arvalid && arready_r;

    always_comb begin
        status = 32'h0000_0000;
        status[`SLP_STAT_UPWR_BIT] = upwr_s;
        status[`SLP_STAT_OFF_LSB +: 7] = port_off_r;
        status[`SLP_STAT_SWAP_LSB +: 7] = swap_r;
        status[`SLP_STAT_GANG_BIT] = gang_r;
        status[`SLP_STAT_DONE_BIT] = (state_r == SLP_RUN);
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        unique case (s_axi_araddr)
            `SLP_CTRL_OFFSET:   rd_word = ctrl_r;
            `SLP_LED_OFFSET:    rd_word = led_r;
            `SLP_STATUS_OFFSET: rd_word = status;
            default:            rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= `SLP_RESP_OKAY;
        end else if (take_ar) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_word;
            rresp_r   <= rd_ok ? `SLP_RESP_OKAY : `SLP_RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
        end else if (!rvalid_r) begin
            arready_r <= 1'b1;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    assign primary_port_indicator_out   = pri_if.pin_out;
    assign primary_port_indicator_oe    = pri_if.pin_oe;
    assign secondary_port_indicator_out = sec_if.pin_out;
    assign secondary_port_indicator_oe  = sec_if.pin_oe;
    assign port_power_enable            = pwr_r;
    assign port_disabled                = port_off_r;
    assign data_line_swap               = swap_r;
    assign gang_mode                    = gang_r;
    assign upstream_pullup_enable       = pullup_r;
endmodule
`default_nettype wire

// File: hw/slp_sync2.sv
`timescale 1ns/100ps
`default_nettype none
module slp_sync2 #(
    parameter int W = 1
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule
`default_nettype wire

// File: include/slp_defines.svh
`ifndef SLP_DEFINES_SVH
`define SLP_DEFINES_SVH

// register byte offsets
`define SLP_CTRL_OFFSET        8'h00
`define SLP_LED_OFFSET         8'h04
`define SLP_STATUS_OFFSET      8'h08

// control register fields
`define SLP_CTRL_LED_EN_BIT    0
`define SLP_CTRL_PWR_LSB       1
`define SLP_CTRL_RESET         32'h0000_0000

// led register fields: primary at bit p, secondary at bit 8+p
`define SLP_LED_PRI_LSB        1
`define SLP_LED_SEC_LSB        11
`define SLP_LED_RESET          32'h0000_0000

// status register fields
`define SLP_STAT_UPWR_BIT      0
`define SLP_STAT_OFF_LSB       1
`define SLP_STAT_SWAP_LSB      9
`define SLP_STAT_GANG_BIT      16
`define SLP_STAT_DONE_BIT      17

// defaults when a strap is not enabled
`define SLP_DEFAULT_PORT_OFF   7'h00
`define SLP_DEFAULT_SWAP       7'h00
`define SLP_DEFAULT_GANG       1'b0

// cycles after reset release before straps are latched (covers the synchroniser)
`define SLP_SETTLE_CYCLES      2'h3

// axi response codes
`define SLP_RESP_OKAY          2'h0
`define SLP_RESP_SLVERR        2'h2

`endif

// File: include/slp_led_if.sv
`timescale 1ns/100ps
`default_nettype none
interface slp_led_if #(parameter int W = 7);
    logic [W-1:0] lit;
    logic [W-1:0] active_low;
    logic         drive;
    logic [W-1:0] pin_out;
    logic [W-1:0] pin_oe;
    modport ctrl (output lit, output active_low, output drive, input pin_out, input pin_oe);
    modport drv  (input lit, input active_low, input drive, output pin_out, output pin_oe);
endinterface
`default_nettype wire

// File: include/slp_pkg.sv
package slp_pkg;
    typedef logic [7:1] slp_port_t;
    typedef logic [7:3] slp_sec_t;
    typedef enum logic [0:0] {
        SLP_SETTLE,
        SLP_RUN
    } slp_state_e;
endpackage
